// >>> design/rews_dev.sv
// transceiver end: register bank, state commands, auto ack and gain control
// assumes the radio core events on the user side are on clk, one-cycle pulses
`timescale 1ns/1ps
`default_nettype none
`include "rews_defs.svh"
module rews_dev import rews_pkg::*; (
  input wire logic clk,
  input wire logic rst_n,
  rews_if.dev bus,
  input wire logic chan_lock,
  input wire logic off_fail,
  input wire logic auto_transmit_prepare_state,
  input wire logic frame_end,
  input wire logic frame_ack_req,
  input wire logic frame_pass,
  input wire logic gain_hold,
  input wire logic gain_release,
  input wire logic frame_start,
  input wire logic hdr_invalid,
  output logic [2:0] radio_state,
  output logic reduced_power_mode,
  output logic [7:0] pll_value,
  output logic [4:0] tx_power,
  output logic ack_tx,
  output logic agc_stuck
);
  logic [2:0] state_r; // current radio state
  rews_byte_t pll_r; // pll control register
  rews_byte_t modem_r; // modem config register
  rews_byte_t mac_r; // mac control register
  logic [4:0] pwr_r; // tx power level
  logic lock_seen_r; // rx ready already reported
  logic bad_rq_r; // last frame failed filter with ack request
  logic ack_pend_r; // ack scheduled
  logic [7:0] ack_cnt_r; // turnaround countdown
  logic stuck_r; // gain control hung
  logic held_r; // gain currently held
  logic legacy; // legacy o-qpsk reception enabled
  logic wr_cmd; // command write this cycle

  assign wr_cmd = bus.req_we && bus.req_addr == `RW_A_CMD;
  assign legacy = modem_r[`RW_F_PT] == `RW_PT_LEGACY && modem_r[`RW_F_CHIP] > 2'h1 &&
    (modem_r[`RW_F_RXM] == 2'h1 || modem_r[`RW_F_RXM] == 2'h2);

  //////////////////////////////////////////////////////////////////////////////
  // configuration registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pll_r <= 8'h00;
      modem_r <= 8'h00;
      mac_r <= `RW_MAC_RST;
      pwr_r <= `RW_TXPWR_RST;
    end else if (bus.req_we) begin
      case (bus.req_addr)
        `RW_A_PLL: pll_r <= bus.req_wdata;
        `RW_A_MODEM: modem_r <= bus.req_wdata;
        `RW_A_MAC: mac_r <= bus.req_wdata;
        `RW_A_TXPWR: pwr_r <= bus.req_wdata[4:0];
        default: ;
      endcase
    end
  end

  // read data one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bus.rsp_rdata <= 8'h00;
    end else if (bus.req_re) begin
      case (bus.req_addr)
        `RW_A_STATE: bus.rsp_rdata <= {5'h00, state_r};
        `RW_A_PLL: bus.rsp_rdata <= pll_r;
        `RW_A_MODEM: bus.rsp_rdata <= modem_r;
        `RW_A_MAC: bus.rsp_rdata <= mac_r;
        `RW_A_TXPWR: bus.rsp_rdata <= {3'h0, pwr_r};
        default: bus.rsp_rdata <= 8'h00;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // state machine commands; an off command can be lost outside sleep
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_r <= `RW_ST_OFF;
    end else if (wr_cmd) begin
      if (bus.req_wdata[2:0] == `RW_ST_OFF && state_r != `RW_ST_SLEEP && off_fail) begin
        state_r <= `RW_ST_TRANS;
      end else begin
        state_r <= bus.req_wdata[2:0];
      end
    end else if (auto_transmit_prepare_state && state_r == `RW_ST_RX) begin
      state_r <= `RW_ST_TXSET; // automatic rx to tx-prepare
    end
  end

  // rx ready and rx left events for the pll handling on the far end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lock_seen_r <= 1'b0;
      bus.ev_rx_ready <= 1'b0;
      bus.ev_rx_left <= 1'b0;
    end else begin
      bus.ev_rx_ready <= state_r == `RW_ST_RX && chan_lock && !lock_seen_r;
      bus.ev_rx_left <= state_r != `RW_ST_RX && lock_seen_r;
      lock_seen_r <= state_r == `RW_ST_RX && (lock_seen_r || chan_lock);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // auto ack; the stale request of a filtered frame leaks into the next one
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bad_rq_r <= 1'b0;
      ack_pend_r <= 1'b0;
      ack_cnt_r <= 8'h00;
      ack_tx <= 1'b0;
    end else begin
      ack_tx <= 1'b0;
      if (frame_end) begin
        bad_rq_r <= !frame_pass && frame_ack_req;
      end
      if (frame_end && frame_pass && (frame_ack_req || bad_rq_r) && mac_r[`RW_B_AACK]) begin
        ack_pend_r <= 1'b1;
        ack_cnt_r <= `RW_ACK_TURN_CYC;
      end else if (ack_pend_r && !mac_r[`RW_B_AACK]) begin
        ack_pend_r <= 1'b0; // disabling auto ack drops a pending ack
      end else if (ack_pend_r) begin
        ack_cnt_r <= ack_cnt_r - 8'h01;
        if (ack_cnt_r == 8'h01) begin
          ack_pend_r <= 1'b0;
          ack_tx <= 1'b1;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // gain control; an invalid legacy header can leave the gain held
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      held_r <= 1'b0;
      stuck_r <= 1'b0;
    end else if (!mac_r[`RW_B_BBON]) begin
      held_r <= 1'b0; // baseband restart clears the hang
      stuck_r <= 1'b0;
    end else begin
      if (gain_hold) begin
        held_r <= 1'b1;
      end else if (gain_release && !stuck_r) begin
        held_r <= 1'b0;
      end
      if (hdr_invalid && held_r && legacy) begin
        stuck_r <= 1'b1;
      end
    end
  end

  // interrupt events toward the controller; a hung agc hides frame starts and gain releases
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bus.ev_frame_end <= 1'b0;
      bus.ev_ack_req <= 1'b0;
      bus.ev_gain_hold <= 1'b0;
      bus.ev_gain_release <= 1'b0;
      bus.ev_frame_start <= 1'b0;
    end else begin
      bus.ev_frame_end <= frame_end;
      bus.ev_ack_req <= frame_end && frame_ack_req;
      bus.ev_gain_hold <= gain_hold && mac_r[`RW_B_BBON];
      bus.ev_gain_release <= gain_release && !stuck_r && mac_r[`RW_B_BBON];
      bus.ev_frame_start <= frame_start && !stuck_r && mac_r[`RW_B_BBON];
    end
  end

  assign radio_state = state_r;
  assign reduced_power_mode = modem_r[`RW_B_OQ_LP] || modem_r[`RW_B_FSK_LP];
  assign pll_value = pll_r;
  assign tx_power = pwr_r;
  assign agc_stuck = stuck_r;
endmodule
`default_nettype wire

// >>> design/rews_host.sv
// controller end: workaround sequencer driving the transceiver control port
// assumes the transceiver answers reads one cycle later and never stalls
`timescale 1ns/1ps
`default_nettype none
`include "rews_defs.svh"
module rews_host import rews_pkg::*; #(
  parameter int WD_LONG_CYC = `RW_WD_LONG_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  rews_if.host bus,
  input wire rews_addr_t sw_addr,
  input wire rews_byte_t sw_wdata,
  input wire logic sw_we,
  input wire logic sw_re,
  output rews_byte_t sw_rdata,
  output logic irq
);
  localparam logic [16:0] WD_SHORT = 17'(`RW_WD_SHORT_CYC);
  localparam logic [16:0] WD_LONG = 17'(WD_LONG_CYC);

  rews_byte_t ctrl_r; // mode and shadow bits
  rews_byte_t mode_r; // band [1:0], option [4:2], scheme [7:5]
  logic [4:0] pwr_req_r; // requested tx power
  logic [4:0] pwr_set_r; // power actually written
  logic [4:0] stat_r; // sticky events
  logic [4:0] mask_r; // interrupt mask
  logic [4:0] stat_set; // events this cycle
  logic [3:0] retry_r; // off command retries
  rews_seq_e seq_r; // sequencer state
  logic pend_pll9_r, pend_pll8_r, pend_ack_r, pend_bb_r, pend_off_r, pend_pwr_r;
  logic pll_is8_r; // pll write in flight is the 8 value
  logic wd_run_r; // gain hold watchdog running
  logic [16:0] wd_cnt_r; // watchdog countdown
  logic wd_fire; // watchdog expired this cycle
  logic sw_cmd; // software command write
  logic [4:0] cap; // power cap for the current mode
  logic idle_go; // sequencer free to start

  assign sw_cmd = sw_we && sw_addr == `RW_S_CMD;
  assign idle_go = seq_r == SQ_IDLE;

  // ofdm power cap lookup; schemes 0 to 3 are unrestricted
  function automatic logic [4:0] ofdm_cap(input rews_byte_t m);
    logic [4:0] c;
    c = `RW_NOCAP;
    case (m)
      {3'h6, 3'h4, 2'h0}: c = 5'h1d;
      {3'h4, 3'h2, 2'h1}: c = 5'h1c;
      {3'h5, 3'h2, 2'h1}: c = 5'h17;
      {3'h5, 3'h3, 2'h1}: c = 5'h1a;
      {3'h6, 3'h3, 2'h1}: c = 5'h17;
      {3'h5, 3'h4, 2'h1}: c = 5'h1a;
      {3'h6, 3'h4, 2'h1}: c = 5'h17;
      {3'h4, 3'h2, 2'h2}: c = 5'h1a;
      {3'h5, 3'h2, 2'h2}: c = 5'h19;
      {3'h4, 3'h3, 2'h2}: c = 5'h1a;
      {3'h5, 3'h3, 2'h2}: c = 5'h19;
      {3'h6, 3'h3, 2'h2}: c = 5'h18;
      {3'h4, 3'h4, 2'h2}: c = 5'h1a;
      {3'h5, 3'h4, 2'h2}: c = 5'h19;
      {3'h6, 3'h4, 2'h2}: c = 5'h17;
      default: c = `RW_NOCAP;
    endcase
    return c;
  endfunction

  assign cap = ctrl_r[`RW_B_OFDM] ? ofdm_cap(mode_r) : `RW_NOCAP;

  //////////////////////////////////////////////////////////////////////////////
  // software registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl_r <= 8'h06;
      mode_r <= 8'h00;
      pwr_req_r <= `RW_TXPWR_RST;
      mask_r <= 5'h00;
    end else if (sw_we) begin
      case (sw_addr)
        `RW_S_CTRL: ctrl_r <= sw_wdata;
        `RW_S_MODE: mode_r <= sw_wdata;
        `RW_S_PWR: pwr_req_r <= sw_wdata[4:0];
        `RW_S_MASK: mask_r <= sw_wdata[4:0];
        default: ;
      endcase
    end
  end

  // read back, one cycle after the strobe
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sw_rdata <= 8'h00;
    end else if (sw_re) begin
      case (sw_addr)
        `RW_S_CTRL: sw_rdata <= ctrl_r;
        `RW_S_MODE: sw_rdata <= mode_r;
        `RW_S_PWR: sw_rdata <= {3'h0, pwr_set_r};
        `RW_S_STAT: sw_rdata <= {3'h0, stat_r};
        `RW_S_MASK: sw_rdata <= {3'h0, mask_r};
        `RW_S_INFO: sw_rdata <= {retry_r, 3'h0, !idle_go};
        default: sw_rdata <= 8'h00;
      endcase
    end
  end

  // sticky status, write one to clear; a new event beats the clear
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stat_r <= 5'h00;
    end else if (sw_we && sw_addr == `RW_S_STAT) begin
      stat_r <= (stat_r & ~sw_wdata[4:0]) | stat_set;
    end else begin
      stat_r <= stat_r | stat_set;
    end
  end

  assign irq = |(stat_r & mask_r);

  //////////////////////////////////////////////////////////////////////////////
  // gain hold watchdog
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wd_run_r <= 1'b0;
      wd_cnt_r <= 17'h00000;
    end else if (bus.ev_gain_hold && ctrl_r[`RW_B_WDEN] && ctrl_r[`RW_F_CRXM] != 2'h0) begin
      wd_run_r <= 1'b1;
      wd_cnt_r <= ctrl_r[`RW_F_CRXM] == 2'h1 ? WD_SHORT : WD_LONG;
    end else if (bus.ev_gain_release || bus.ev_frame_start || wd_fire) begin
      wd_run_r <= 1'b0;
    end else if (wd_run_r) begin
      wd_cnt_r <= wd_cnt_r - 17'h00001;
    end
  end

  assign wd_fire = wd_run_r && wd_cnt_r == 17'h00001;

  //////////////////////////////////////////////////////////////////////////////
  // pending work; each flag drops when its sequence is started
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pend_pll9_r <= 1'b0;
      pend_pll8_r <= 1'b0;
      pend_ack_r <= 1'b0;
      pend_bb_r <= 1'b0;
      pend_off_r <= 1'b0;
      pend_pwr_r <= 1'b0;
    end else begin
      if (bus.ev_frame_end && !bus.ev_ack_req && ctrl_r[`RW_B_CAACK]) begin
        pend_ack_r <= 1'b1;
      end else if (idle_go) begin
        pend_ack_r <= 1'b0;
      end
      if (wd_fire) begin
        pend_bb_r <= 1'b1;
      end else if (idle_go && !pend_ack_r) begin
        pend_bb_r <= 1'b0;
      end
      if (ctrl_r[`RW_B_LPM] && (bus.ev_rx_left || (sw_cmd && sw_wdata[`RW_B_CHANREQ]))) begin
        pend_pll8_r <= 1'b1;
        pend_pll9_r <= 1'b0;
      end else if (ctrl_r[`RW_B_LPM] && bus.ev_rx_ready) begin
        pend_pll9_r <= 1'b1;
      end else if (idle_go && !pend_ack_r && !pend_bb_r) begin
        pend_pll8_r <= 1'b0;
        if (!pend_pll8_r) begin
          pend_pll9_r <= 1'b0;
        end
      end
      if (sw_cmd && sw_wdata[`RW_B_OFFREQ]) begin
        pend_off_r <= 1'b1;
      end else if (seq_r == SQ_OFF_CMD) begin
        pend_off_r <= 1'b0;
      end
      if (sw_cmd && sw_wdata[`RW_B_PWRREQ]) begin
        pend_pwr_r <= 1'b1;
      end else if (seq_r == SQ_PWR) begin
        pend_pwr_r <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // sequencer; the state names the access on the port in that cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      seq_r <= SQ_IDLE;
      bus.req_we <= 1'b0;
      bus.req_re <= 1'b0;
      bus.req_addr <= 4'h0;
      bus.req_wdata <= 8'h00;
      pll_is8_r <= 1'b0;
      retry_r <= 4'h0;
      pwr_set_r <= `RW_TXPWR_RST;
    end else begin
      bus.req_we <= 1'b0;
      bus.req_re <= 1'b0;
      case (seq_r)
        SQ_IDLE: begin
          // ack fix first: it races the automatic ack turnaround
          if (pend_ack_r) begin
            seq_r <= SQ_ACK_OFF;
            bus.req_we <= 1'b1;
            bus.req_addr <= `RW_A_MAC;
            bus.req_wdata <= {6'h00, ctrl_r[`RW_B_CBBEN], 1'b0};
          end else if (pend_bb_r) begin
            seq_r <= SQ_BB_OFF;
            bus.req_we <= 1'b1;
            bus.req_addr <= `RW_A_MAC;
            bus.req_wdata <= {6'h00, 1'b0, ctrl_r[`RW_B_CAACK]};
          end else if (pend_pll8_r || pend_pll9_r) begin
            seq_r <= SQ_PLL;
            pll_is8_r <= pend_pll8_r;
            bus.req_we <= 1'b1;
            bus.req_addr <= `RW_A_PLL;
            bus.req_wdata <= pend_pll8_r ? `RW_PLL_LPM_OFF : `RW_PLL_LPM_ON;
          end else if (pend_off_r) begin
            seq_r <= SQ_OFF_CMD;
            retry_r <= 4'h0;
            bus.req_we <= 1'b1;
            bus.req_addr <= `RW_A_CMD;
            bus.req_wdata <= {5'h00, `RW_ST_OFF};
          end else if (pend_pwr_r) begin
            seq_r <= SQ_PWR;
            pwr_set_r <= pwr_req_r > cap ? cap : pwr_req_r;
            bus.req_we <= 1'b1;
            bus.req_addr <= `RW_A_TXPWR;
            bus.req_wdata <= {3'h0, pwr_req_r > cap ? cap : pwr_req_r};
          end
        end
        SQ_ACK_OFF: begin
          seq_r <= SQ_ACK_ON;
          bus.req_we <= 1'b1;
          bus.req_wdata <= {6'h00, ctrl_r[`RW_B_CBBEN], 1'b1};
        end
        SQ_BB_OFF: begin
          seq_r <= SQ_BB_ON;
          bus.req_we <= 1'b1;
          bus.req_wdata <= {6'h00, 1'b1, ctrl_r[`RW_B_CAACK]};
        end
        SQ_OFF_CMD: begin
          seq_r <= SQ_OFF_RD;
          bus.req_re <= 1'b1;
          bus.req_addr <= `RW_A_STATE;
        end
        SQ_OFF_RD: seq_r <= SQ_OFF_CHK;
        SQ_OFF_CHK: begin
          if (bus.rsp_rdata[2:0] == `RW_ST_OFF) begin
            seq_r <= SQ_IDLE;
          end else begin
            seq_r <= SQ_OFF_CMD;
            retry_r <= retry_r + 4'h1;
            bus.req_we <= 1'b1;
            bus.req_addr <= `RW_A_CMD;
            bus.req_wdata <= {5'h00, `RW_ST_OFF};
          end
        end
        SQ_PLL, SQ_ACK_ON, SQ_BB_ON, SQ_PWR: seq_r <= SQ_IDLE;
        default: seq_r <= SQ_IDLE;
      endcase
    end
  end

  // completion events into the status register
  always_comb begin
    stat_set = 5'h00;
    stat_set[`RW_E_OFF] = seq_r == SQ_OFF_CHK && bus.rsp_rdata[2:0] == `RW_ST_OFF;
    stat_set[`RW_E_WD] = wd_fire;
    stat_set[`RW_E_ACK] = seq_r == SQ_ACK_ON;
    stat_set[`RW_E_CHAN] = seq_r == SQ_PLL && pll_is8_r;
    stat_set[`RW_E_PWR] = seq_r == SQ_PWR;
  end
endmodule
`default_nettype wire

// >>> shared/rews_defs.svh
// register map, field positions, codes and timing counts shared by both ends
// assumes a 20 MHz clock on both ends
`ifndef REWS_DEFS_SVH
`define REWS_DEFS_SVH
// transceiver register offsets (device side)
`define RW_A_STATE 4'h0
`define RW_A_CMD 4'h1
`define RW_A_PLL 4'h2
`define RW_A_MODEM 4'h3
`define RW_A_MAC 4'h4
`define RW_A_TXPWR 4'h5
// modem config fields
`define RW_F_PT 1:0
`define RW_F_CHIP 3:2
`define RW_F_RXM 5:4
`define RW_B_OQ_LP 6
`define RW_B_FSK_LP 7
// mac control fields
`define RW_B_AACK 0
`define RW_B_BBON 1
// radio state and command codes, legacy phy type code
`define RW_ST_SLEEP 3'h1
`define RW_ST_OFF 3'h2
`define RW_ST_TXSET 3'h3
`define RW_ST_TX 3'h4
`define RW_ST_RX 3'h5
`define RW_ST_TRANS 3'h6
`define RW_PT_LEGACY 2'h3
// pll control values
`define RW_PLL_LPM_ON 8'h09
`define RW_PLL_LPM_OFF 8'h08
// reset values and the no-cap power limit
`define RW_MAC_RST 8'h03
`define RW_TXPWR_RST 5'h1f
`define RW_NOCAP 5'h1f
// auto ack turnaround
`define RW_ACK_TURN_CYC 8'h40
// gain hold watchdog periods
`define RW_CLK_MHZ 20
`define RW_WD_SHORT_US 200
`define RW_WD_LONG_US 6000
`define RW_WD_SHORT_CYC (`RW_WD_SHORT_US * `RW_CLK_MHZ)
`define RW_WD_LONG_CYC (`RW_WD_LONG_US * `RW_CLK_MHZ)
// controller software registers
`define RW_S_CTRL 4'h0
`define RW_S_CMD 4'h1
`define RW_S_MODE 4'h2
`define RW_S_PWR 4'h3
`define RW_S_STAT 4'h4
`define RW_S_MASK 4'h5
`define RW_S_INFO 4'h6
`define RW_B_LPM 0
`define RW_B_CAACK 1
`define RW_B_CBBEN 2
`define RW_B_WDEN 3
`define RW_F_CRXM 5:4
`define RW_B_OFDM 6
`define RW_B_OFFREQ 0
`define RW_B_CHANREQ 1
`define RW_B_PWRREQ 2
`define RW_E_OFF 0
`define RW_E_WD 1
`define RW_E_ACK 2
`define RW_E_CHAN 3
`define RW_E_PWR 4
`endif

// >>> shared/rews_if.sv
// control port and interrupt lines between controller and transceiver
// assumes both ends on the same clock; events are one-cycle pulses
`timescale 1ns/1ps
`default_nettype none
interface rews_if;
  import rews_pkg::*;
  logic req_we; // write strobe
  logic req_re; // read strobe
  rews_addr_t req_addr; // register offset
  rews_byte_t req_wdata; // write data
  rews_byte_t rsp_rdata; // read data, cycle after req_re
  logic ev_frame_end; // frame end interrupt
  logic ev_ack_req; // ack request bit of that frame
  logic ev_gain_hold; // gain hold interrupt
  logic ev_gain_release; // gain release interrupt
  logic ev_frame_start; // frame start interrupt
  logic ev_rx_ready; // rx reached and channel locked
  logic ev_rx_left; // rx state left
  modport dev (input req_we, req_re, req_addr, req_wdata,
    output rsp_rdata, ev_frame_end, ev_ack_req, ev_gain_hold, ev_gain_release,
    ev_frame_start, ev_rx_ready, ev_rx_left);
  modport host (output req_we, req_re, req_addr, req_wdata,
    input rsp_rdata, ev_frame_end, ev_ack_req, ev_gain_hold, ev_gain_release,
    ev_frame_start, ev_rx_ready, ev_rx_left);
endinterface
`default_nettype wire

// >>> shared/rews_pkg.sv
// types shared by the controller and the transceiver end
// assumes rews_defs.svh for all numeric values
`default_nettype none
package rews_pkg;
  typedef logic [7:0] rews_byte_t; // one register byte
  typedef logic [3:0] rews_addr_t; // register offset
  typedef enum logic [3:0] {
    SQ_IDLE, SQ_PLL, SQ_ACK_OFF, SQ_ACK_ON, SQ_BB_OFF, SQ_BB_ON,
    SQ_OFF_CMD, SQ_OFF_RD, SQ_OFF_CHK, SQ_PWR
  } rews_seq_e;
endpackage
`default_nettype wire

// >>> sim/rews_chk_sva.sv
// checker on the control port and event lines between the two ends
// assumes one clock domain and the interface signals as plain inputs
`timescale 1ns/1ps
`default_nettype none
`include "rews_defs.svh"
module rews_chk_sva import rews_pkg::*; (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic req_we,
  input wire logic req_re,
  input wire rews_addr_t req_addr,
  input wire rews_byte_t req_wdata,
  input wire rews_byte_t rsp_rdata,
  input wire logic ev_frame_end,
  input wire logic ev_ack_req
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////
  logic mac_wr; // write to mac control
  logic off_wr; // off command written
  logic st_rd; // state register read
  assign mac_wr = req_we && req_addr == `RW_A_MAC;
  assign off_wr = req_we && req_addr == `RW_A_CMD && req_wdata == {5'h0, `RW_ST_OFF};
  assign st_rd = req_re && req_addr == `RW_A_STATE;
  ////////////////////////////////////////////////////////////////
  // one access per cycle on the shared port
  AST_ONE_ACCESS: assert property (!(req_we && req_re))
    else $error("read and write strobes together");
  // auto ack cleared must be set again on the next cycle
  AST_ACK_TOGGLE: assert property (mac_wr && req_wdata[1:0] == 2'h2 |=>
    mac_wr && req_wdata[1:0] == 2'h3) else $error("auto ack not restored");
  // baseband cleared must be enabled again at once
  AST_BB_RESTART: assert property (mac_wr && req_wdata[1:0] == 2'h1 |=>
    mac_wr && req_wdata[1:0] == 2'h3) else $error("baseband not restarted");
  // every off command is followed by a state read
  AST_OFF_READ: assert property (off_wr |=> st_rd)
    else $error("no state read after off command");
  // a state other than off leads to a reissued command
  AST_OFF_RETRY: assert property (off_wr ##1 st_rd ##1
    rsp_rdata[2:0] != `RW_ST_OFF |=> off_wr) else $error("off command not reissued");
  // once off is seen the retries stop
  AST_OFF_STOP: assert property (off_wr ##1 st_rd ##1
    rsp_rdata[2:0] == `RW_ST_OFF |=> !off_wr) else $error("off command after success");
  // only the two pll codes are ever written
  AST_PLL_CODES: assert property (req_we && req_addr == `RW_A_PLL |->
    req_wdata == `RW_PLL_LPM_ON || req_wdata == `RW_PLL_LPM_OFF) else $error("bad pll value");
  // ack request flag only travels with frame end
  AST_ACK_PAIR: assert property (ev_ack_req |-> ev_frame_end)
    else $error("ack request without frame end");
  // power setting never beyond the field
  AST_PWR_RANGE: assert property (req_we && req_addr == `RW_A_TXPWR |->
    req_wdata <= 8'h1f) else $error("power value out of range");
  ////////////////////////////////////////////////////////////////
  COV_OFF_RETRY: cover property (off_wr ##1 st_rd ##2 off_wr);
  COV_ACK_FIX: cover property (mac_wr && req_wdata[1:0] == 2'h2);
  COV_BB_FIX: cover property (mac_wr && req_wdata[1:0] == 2'h1);
endmodule
`default_nettype wire

// >>> sim/tb.sv
// testbench: controller and transceiver joined by the interface
// assumes software port answers reads one cycle later, no stalls
`timescale 1ns/1ps
`default_nettype none
`include "rews_defs.svh"
module tb import rews_pkg::*;;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  rews_addr_t sw_addr = 4'h0;
  rews_byte_t sw_wdata = 8'h00;
  rews_byte_t sw_rdata;
  rews_byte_t rdv; // last read value
  logic sw_we = 1'b0, sw_re = 1'b0, irq;
  logic chan_lock = 1'b0, off_fail = 1'b0, auto_transmit_prepare_state = 1'b0, frame_end = 1'b0;
  logic frame_ack_req = 1'b0, frame_pass = 1'b0, gain_hold = 1'b0, gain_release = 1'b0;
  logic frame_start = 1'b0, hdr_invalid = 1'b0, rpm, ack_tx, agc_stuck;
  logic [2:0] radio_state;
  logic [7:0] pll_value;
  logic [4:0] tx_power;
  int fail_count = 0, n_checks = 0, cyc = 0, ack_cnt = 0, i;
  // power table: mode byte, request, expected applied value
  rews_byte_t pmode[6] = '{8'ha9, 8'hcd, 8'hce, 8'hd0, 8'h6d, 8'h89};
  rews_byte_t preq[6] = '{8'h1f, 8'h1f, 8'h1f, 8'h1f, 8'h1f, 8'h14};
  rews_byte_t pcap[6] = '{8'h17, 8'h17, 8'h18, 8'h1d, 8'h1f, 8'h14};
  always #25 clk = ~clk;
  ////////////////////////////////////////////////////////////////
  rews_if i_rews_if();
  rews_host #(.WD_LONG_CYC(300)) i_rews_host(.clk(clk), .rst_n(rst_n), .bus(i_rews_if),
    .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_we(sw_we), .sw_re(sw_re),
    .sw_rdata(sw_rdata), .irq(irq));
  rews_dev i_rews_dev(.clk(clk), .rst_n(rst_n), .bus(i_rews_if), .chan_lock(chan_lock),
    .off_fail(off_fail), .auto_transmit_prepare_state(auto_transmit_prepare_state), .frame_end(frame_end),
    .frame_ack_req(frame_ack_req), .frame_pass(frame_pass), .gain_hold(gain_hold),
    .gain_release(gain_release), .frame_start(frame_start), .hdr_invalid(hdr_invalid),
    .radio_state(radio_state), .reduced_power_mode(rpm), .pll_value(pll_value),
    .tx_power(tx_power), .ack_tx(ack_tx), .agc_stuck(agc_stuck));
  rews_chk_sva i_rews_chk_sva(.clk(clk), .rst_n(rst_n), .req_we(i_rews_if.req_we),
    .req_re(i_rews_if.req_re), .req_addr(i_rews_if.req_addr),
    .req_wdata(i_rews_if.req_wdata), .rsp_rdata(i_rews_if.rsp_rdata),
    .ev_frame_end(i_rews_if.ev_frame_end), .ev_ack_req(i_rews_if.ev_ack_req));
  ////////////////////////////////////////////////////////////////
  // hang guard, well above the test length
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      fail_count++;
      conclude();
    end
  end
  // acks sent by the transceiver
  always @(posedge clk) if (ack_tx === 1'b1) ack_cnt++;
  ////////////////////////////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // one-cycle write strobe
  task automatic wr(input rews_addr_t a, input rews_byte_t d);
    @(posedge clk);
    sw_addr <= a;
    sw_wdata <= d;
    sw_we <= 1'b1;
    @(posedge clk);
    sw_we <= 1'b0;
  endtask
  // read strobe, data taken the cycle after
  task automatic rd(input rews_addr_t a);
    @(posedge clk);
    sw_addr <= a;
    sw_re <= 1'b1;
    @(posedge clk);
    sw_re <= 1'b0;
    #1 rdv = sw_rdata;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rdchk(input rews_addr_t a, input rews_byte_t exp);
    rd(a);
    chk(rdv, exp);
  endtask
  // poll a status bit, bounded
  task automatic poll(input int b);
    for (int k = 0; k < 300; k++) begin
      rd(`RW_S_STAT);
      if (rdv[b] === 1'b1) break;
    end
    chk({7'h0, rdv[b]}, 8'h01);
  endtask
  // one frame end with its header flags
  task automatic frame(input logic ar, input logic ps);
    @(posedge clk);
    frame_end <= 1'b1;
    frame_ack_req <= ar;
    frame_pass <= ps;
    @(posedge clk);
    frame_end <= 1'b0;
  endtask
  task automatic hold_pulse;
    @(posedge clk);
    gain_hold <= 1'b1;
    @(posedge clk);
    gain_hold <= 1'b0;
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    rdchk(`RW_S_CTRL, 8'h06);
    chk({5'h0, radio_state}, 8'h02);
    chk({3'h0, tx_power}, 8'h1f);
    chk({6'h0, rpm, agc_stuck}, 8'h00);
    chk({7'h0, irq}, 8'h00);
    rdchk(4'hf, 8'h00); // unmapped read gives zero
    wr(`RW_S_MASK, 8'h1f);
    $display("test reset done");
    // off command failing until the fault goes away
    @(posedge clk) off_fail <= 1'b1;
    wr(`RW_S_CMD, 8'h01);
    tick(20);
    chk({5'h0, radio_state}, 8'h06);
    @(posedge clk) off_fail <= 1'b0;
    poll(`RW_E_OFF);
    chk({5'h0, radio_state}, 8'h02);
    chk({7'h0, irq}, 8'h01);
    rd(`RW_S_INFO);
    chk({7'h0, rdv[7:4] != 4'h0}, 8'h01);
    wr(`RW_S_STAT, 8'h1f);
    rdchk(`RW_S_STAT, 8'h00);
    chk({7'h0, irq}, 8'h00);
    $display("test off done");
    // channel change with reduced power in use
    wr(`RW_S_CTRL, 8'h07);
    wr(`RW_S_CMD, 8'h02);
    poll(`RW_E_CHAN);
    chk(pll_value, 8'h08);
    wr(`RW_S_STAT, 8'h1f);
    $display("test pll done");
    // normal ack, then filtered frame followed by frame without request
    frame(1'b1, 1'b1);
    tick(100);
    chk(ack_cnt[7:0], 8'h01);
    frame(1'b1, 1'b0);
    tick(5);
    frame(1'b0, 1'b1);
    poll(`RW_E_ACK);
    tick(100);
    chk(ack_cnt[7:0], 8'h01);
    wr(`RW_S_CTRL, 8'h05);
    frame(1'b1, 1'b0);
    frame(1'b0, 1'b1);
    tick(100);
    chk(ack_cnt[7:0], 8'h02);
    wr(`RW_S_STAT, 8'h1f);
    $display("test ack done");
    // watchdog, short period: stopped, then expiring
    wr(`RW_S_CTRL, 8'h1e);
    hold_pulse();
    tick(100);
    @(posedge clk) gain_release <= 1'b1;
    @(posedge clk) gain_release <= 1'b0;
    tick(4100);
    rdchk(`RW_S_STAT, 8'h00);
    hold_pulse();
    tick(3980);
    rdchk(`RW_S_STAT, 8'h00);
    tick(40);
    rdchk(`RW_S_STAT, 8'h02);
    wr(`RW_S_STAT, 8'h1f);
    // long period, shortened by parameter to 300
    wr(`RW_S_CTRL, 8'h2e);
    hold_pulse();
    tick(285);
    rdchk(`RW_S_STAT, 8'h00);
    tick(30);
    rdchk(`RW_S_STAT, 8'h02);
    wr(`RW_S_STAT, 8'h1f);
    $display("test watchdog done");
    // power caps with the power event masked off
    wr(`RW_S_MASK, 8'h0f);
    wr(`RW_S_CTRL, 8'h46);
    for (i = 0; i < 6; i++) begin
      wr(`RW_S_MODE, pmode[i]);
      wr(`RW_S_PWR, preq[i]);
      wr(`RW_S_CMD, 8'h04);
      poll(`RW_E_PWR);
      chk({3'h0, tx_power}, pcap[i]);
      rdchk(`RW_S_PWR, pcap[i]);
      chk({7'h0, irq}, 8'h00);
      wr(`RW_S_STAT, 8'h1f);
    end
    $display("test power done");
    conclude();
  end
endmodule
`default_nettype wire
